// File: design/dmcd_regs.svh
// Opcodes, AHB offsets and field layout for the display mode command decoder
`ifndef DMCD_REGS_SVH
`define DMCD_REGS_SVH

`define DMCD_OP_WINDOW_ON   8'h12
`define DMCD_OP_FULL_SCREEN 8'h13
`define DMCD_OP_INVERT_OFF  8'h20
`define DMCD_OP_INVERT_ON   8'h21
`define DMCD_OP_SW_RESET    8'h01
`define DMCD_OP_SCROLL_ON   8'h33
`define DMCD_OP_WINDOW_AREA 8'h30

`define DMCD_ADDR_STATUS    8'h00
`define DMCD_ADDR_CONTROL   8'h04
`define DMCD_ADDR_LAST_OP   8'h08

`define DMCD_BIT_WINDOW     0
`define DMCD_BIT_SCROLL     1
`define DMCD_BIT_INVERT     2
`define DMCD_BIT_AREA_SEEN  3
`define DMCD_BIT_CMD_ENABLE 0

`define DMCD_HTRANS_NONSEQ  2'h2
`define DMCD_HTRANS_SEQ     2'h3
`define DMCD_CTRL_RESET     1'h1
`define DMCD_ZERO_WORD      32'h0000_0000

`endif

// File: design/dmcd_pkg.sv
// Types shared by the display mode command decoder
package dmcd_pkg;

  // Bus slave phase, Gray coded along idle -> data -> idle
  typedef enum logic [1:0] {
    DMCD_BUS_IDLE = 2'h0,
    DMCD_BUS_DATA = 2'h1
  } dmcd_bus_state_t;

endpackage

// File: design/dmcd_top.sv
// Display mode command decoder: host command bus, mode flags, AHB-Lite status
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "dmcd_regs.svh"
module dmcd_top
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        data_command_select_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        read_strobe_n_in,
  input  wire logic [7:0]  host_data_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             window_mode_out,
  output logic             scroll_mode_out,
  output logic             invert_out,
  output logic             window_area_valid_out
);

  //----------------------------------------------------------------
  // Write strobe edge detect
  //----------------------------------------------------------------
  logic       strobe_prev;
  logic       next_strobe_prev;
  logic       cmd_write;
  logic [7:0] opcode;

  // Strobe rises while selected with data_command_select low: a command byte
  always_comb
  begin
    next_strobe_prev = write_strobe_n_in;
    cmd_write        = !chip_select_n_in && !data_command_select_in
                       && write_strobe_n_in && !strobe_prev;
    opcode           = host_data_in;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      strobe_prev <= 1'h1;
    else
      strobe_prev <= next_strobe_prev;
  end

  //----------------------------------------------------------------
  // Mode flags
  //----------------------------------------------------------------
  logic       window_mode;
  logic       scroll_mode;
  logic       invert;
  logic       area_seen;
  logic       cmd_enable;
  logic [7:0] last_op;
  logic       next_window_mode;
  logic       next_scroll_mode;
  logic       next_invert;
  logic       next_area_seen;
  logic [7:0] next_last_op;
  logic       accept;

  // Software can mask the host port for bring-up; enabled by default
  assign accept = cmd_write && cmd_enable;

  // No state gating: every opcode decodes in any mode
  always_comb
  begin
    next_window_mode = window_mode;
    next_scroll_mode = scroll_mode;
    next_invert      = invert;
    next_area_seen   = area_seen;
    next_last_op     = last_op;
    if (accept)
    begin
      next_last_op = opcode;
      case (opcode)
        // Setting an already set flag is a no-op
        `DMCD_OP_WINDOW_ON:
          next_window_mode = 1'h1;
        // Full screen clears window and scroll
        // Repeated clear leaves flags as they are
        `DMCD_OP_FULL_SCREEN:
        begin
          next_window_mode = 1'h0;
          next_scroll_mode = 1'h0;
        end
        `DMCD_OP_INVERT_OFF:
          next_invert = 1'h0;
        `DMCD_OP_INVERT_ON:
          next_invert = 1'h1;
        // Scroll handled elsewhere; only its flag lives here
        `DMCD_OP_SCROLL_ON:
          next_scroll_mode = 1'h1;
        // Note that a window area has been programmed
        `DMCD_OP_WINDOW_AREA:
          next_area_seen = 1'h1;
        `DMCD_OP_SW_RESET:
        begin
          next_window_mode = 1'h0;
          next_scroll_mode = 1'h0;
          next_invert      = 1'h0;
        end
        // Other opcodes leave every flag alone
        default:
          next_last_op = opcode;
      endcase
    end
  end

  // Hardware reset: full screen, window off
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      window_mode <= 1'h0;
      scroll_mode <= 1'h0;
      invert      <= 1'h0;
      area_seen   <= 1'h0;
      last_op     <= 8'h00;
    end
    else
    begin
      window_mode <= next_window_mode;
      scroll_mode <= next_scroll_mode;
      invert      <= next_invert;
      area_seen   <= next_area_seen;
      last_op     <= next_last_op;
    end
  end

  // Window flag drives its output directly, whether or not an area exists
  assign window_mode_out       = window_mode;
  assign scroll_mode_out       = scroll_mode;
  assign invert_out            = invert;
  assign window_area_valid_out = area_seen;

  //----------------------------------------------------------------
  // AHB-Lite slave
  //----------------------------------------------------------------
  dmcd_pkg::dmcd_bus_state_t bus_state;
  dmcd_pkg::dmcd_bus_state_t next_bus_state;
  logic [7:0]  bus_addr;
  logic [7:0]  next_bus_addr;
  logic        bus_write;
  logic        next_bus_write;
  logic        next_cmd_enable;
  logic [31:0] next_hrdata;
  logic        addr_phase;

  // Register read mux, reused for the next read data word
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] word;
    word = `DMCD_ZERO_WORD;
    case (addr)
      `DMCD_ADDR_STATUS:
      begin
        word[`DMCD_BIT_WINDOW]    = window_mode;
        word[`DMCD_BIT_SCROLL]    = scroll_mode;
        word[`DMCD_BIT_INVERT]    = invert;
        word[`DMCD_BIT_AREA_SEEN] = area_seen;
      end
      `DMCD_ADDR_CONTROL:
        word[`DMCD_BIT_CMD_ENABLE] = cmd_enable;
      `DMCD_ADDR_LAST_OP:
        word[7:0] = last_op;
      default:
        word = `DMCD_ZERO_WORD;
    endcase
    return word;
  endfunction

  // One wait-free slave: data phase follows every accepted address phase
  always_comb
  begin
    addr_phase      = hsel_in && hready_in && (htrans_in == `DMCD_HTRANS_NONSEQ
                      || htrans_in == `DMCD_HTRANS_SEQ);
    next_bus_state  = addr_phase ? dmcd_pkg::DMCD_BUS_DATA : dmcd_pkg::DMCD_BUS_IDLE;
    next_bus_addr   = addr_phase ? haddr_in[7:0] : bus_addr;
    next_bus_write  = addr_phase && hwrite_in;
    next_cmd_enable = cmd_enable;
    next_hrdata     = hrdata_out;
    case (bus_state)
      dmcd_pkg::DMCD_BUS_DATA:
        if (bus_write && bus_addr == `DMCD_ADDR_CONTROL)
          next_cmd_enable = hwdata_in[`DMCD_BIT_CMD_ENABLE];
      dmcd_pkg::DMCD_BUS_IDLE:
        next_cmd_enable = cmd_enable;
      default:
        next_cmd_enable = cmd_enable;
    endcase
    // Read data registered at address phase so hrdata comes from a flop
    if (addr_phase && !hwrite_in)
      next_hrdata = read_word(haddr_in[7:0]);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bus_state     <= dmcd_pkg::DMCD_BUS_IDLE;
      bus_addr      <= 8'h00;
      bus_write     <= 1'h0;
      cmd_enable    <= `DMCD_CTRL_RESET;
      hrdata_out    <= `DMCD_ZERO_WORD;
      hreadyout_out <= 1'h1;
      hresp_out     <= 1'h0;
    end
    else
    begin
      bus_state     <= next_bus_state;
      bus_addr      <= next_bus_addr;
      bus_write     <= next_bus_write;
      cmd_enable    <= next_cmd_enable;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= 1'h1;
      hresp_out     <= 1'h0;
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  a_window_set: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_WINDOW_ON |=> window_mode)
    else $error("window mode not set by 12h");

  a_full_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_FULL_SCREEN |=> !window_mode && !scroll_mode)
    else $error("full screen did not clear flags");

  a_window_stable: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    window_mode && accept && opcode == `DMCD_OP_WINDOW_ON
    |=> window_mode && $stable(invert) && $stable(scroll_mode))
    else $error("repeated 12h changed state");

  a_full_noop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !window_mode && !scroll_mode && accept && opcode == `DMCD_OP_FULL_SCREEN
    |=> !window_mode && !scroll_mode && $stable(invert))
    else $error("repeated 13h changed state");

  a_invert_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_INVERT_OFF
    |=> !invert && $stable(window_mode) && $stable(scroll_mode))
    else $error("20h misbehaved");

  a_invert_keep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !invert && accept && opcode == `DMCD_OP_INVERT_OFF |=> !invert)
    else $error("20h set inversion");

  a_invert_on: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_INVERT_ON |=> invert)
    else $error("21h did not invert");

  a_flags_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !accept |=> $stable(window_mode) && $stable(scroll_mode) && $stable(invert))
    else $error("flag changed without command");

  a_sw_reset: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_SW_RESET |=> !window_mode && !invert)
    else $error("software reset left mode set");

  a_any_state: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cmd_write && cmd_enable |=> last_op == $past(host_data_in))
    else $error("command not accepted");

  //----------------------------------------------------------------
  // Reset defaults and flag independence checks
  //----------------------------------------------------------------

  // Hardware reset release must leave full screen
  a_reset_window: assert property (@(posedge sys_clk_in)
    $rose(reset_n_in) |-> !window_mode && !scroll_mode)
    else $error("reset left window or scroll set");

  // Hardware reset release must leave inversion off
  a_reset_invert: assert property (@(posedge sys_clk_in)
    $rose(reset_n_in) |-> !invert)
    else $error("reset left inversion set");

  // Software reset also clears scroll, like full screen
  a_sw_scroll: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_SW_RESET |=> !scroll_mode)
    else $error("software reset left scroll set");

  // Area command marks the window geometry as present
  a_area_seen: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_WINDOW_AREA |=> area_seen)
    else $error("area command not noted");

  // Area flag only moves on an accepted command
  a_area_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !accept |=> $stable(area_seen))
    else $error("area flag changed without command");

  // Inversion on must not touch the window or scroll flags
  a_invert_iso: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_INVERT_ON |=> $stable(window_mode) && $stable(scroll_mode))
    else $error("21h disturbed mode flags");

  // Window on must not touch inversion
  a_window_iso: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept && opcode == `DMCD_OP_WINDOW_ON |=> $stable(invert))
    else $error("12h disturbed inversion");

  // Masked host port: window, scroll and invert flags may not follow a strobe
  a_masked_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !cmd_enable |=> $stable(window_mode) && $stable(invert) && $stable(scroll_mode))
    else $error("flag changed while port masked");

  // Every accepted opcode is recorded, whatever the mode
  a_last_op: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    accept |=> last_op == $past(opcode))
    else $error("accepted opcode not recorded");

endmodule

// File: tb/dmcd_host_model.sv
// Host processor model driving the parallel command port
`timescale 1ns/10ps
module dmcd_host_model
(
  input  wire logic       sys_clk_in,
  output logic            chip_select_n_out,
  output logic            data_command_select_out,
  output logic            write_strobe_n_out,
  output logic            read_strobe_n_out,
  output logic [7:0]      host_data_out
);
  // Idle bus deselected; idle data lines show a5h at start, then the inverse of the last byte
  initial
  begin
    chip_select_n_out       = 1'h1;
    data_command_select_out = 1'h1;
    write_strobe_n_out      = 1'h1;
    read_strobe_n_out       = 1'h1;
    host_data_out           = 8'ha5;
  end
  // single byte, strobe low one cycle, then rising edge
  // no video port on this block, so sync timing is not modelled
  task automatic send(input logic dc, input logic [7:0] op);
    @(posedge sys_clk_in);
    chip_select_n_out       <= 1'h0;
    data_command_select_out <= dc;
    write_strobe_n_out      <= 1'h0;
    host_data_out           <= op;
    @(posedge sys_clk_in);
    write_strobe_n_out      <= 1'h1;
    @(posedge sys_clk_in);
    chip_select_n_out       <= 1'h1;
    host_data_out           <= ~op;
  endtask
endmodule

// File: tb/tb_display_mode_command_decoder.sv
// Self-checking bench for the display mode command decoder
`timescale 1ns/10ps
`include "dmcd_regs.svh"
module tb_display_mode_command_decoder;
  logic        sys_clk_in;
  logic        reset_n_in;
  logic        cs_n, dc, wr_n, rd_n, win, scr, inv, area, hready, hresp;
  logic [7:0]  hdata;
  logic        hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int          n_mismatch;
  int          tests_run;

  // Free-running 100 MHz clock
  initial sys_clk_in = 1'h0;
  always #5 sys_clk_in = ~sys_clk_in;

  dmcd_host_model host_u (.sys_clk_in(sys_clk_in), .chip_select_n_out(cs_n),
    .data_command_select_out(dc), .write_strobe_n_out(wr_n),
    .read_strobe_n_out(rd_n), .host_data_out(hdata));

  dmcd_top dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .chip_select_n_in(cs_n), .data_command_select_in(dc), .write_strobe_n_in(wr_n),
    .read_strobe_n_in(rd_n), .host_data_in(hdata), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .window_mode_out(win), .scroll_mode_out(scr),
    .invert_out(inv), .window_area_valid_out(area));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the slave's ready; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (hready !== 1'h1 && n < 40);
    if (hready !== 1'h1)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk_in);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= `DMCD_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Flags {area, invert, scroll, window} seen on ports and in STATUS
  task automatic chk_state(input logic [3:0] e);
    logic [31:0] r;
    repeat (2) @(posedge sys_clk_in);
    chk({28'h0, area, inv, scr, win}, {28'h0, e});
    ahb(1'h0, `DMCD_ADDR_STATUS, 32'h0, r);
    chk(r, {28'h0, e});
  endtask

  task automatic cmd(input logic [7:0] op, input logic [3:0] e);
    host_u.send(1'h0, op);
    chk_state(e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    chk_state(4'h0);
    ahb(1'h0, `DMCD_ADDR_CONTROL, 32'h0, r);
    chk(r, 32'h1);
    ahb(1'h1, 32'h0c, 32'hffff_ffff, r);
    ahb(1'h0, 32'h0c, 32'h0, r);
    chk(r, 32'h0);
  endtask

  // Set twice, scroll on, full screen twice
  task automatic t_window;
    logic [31:0] r;
    cmd(`DMCD_OP_WINDOW_ON, 4'h1);
    cmd(`DMCD_OP_WINDOW_ON, 4'h1);
    cmd(`DMCD_OP_SCROLL_ON, 4'h3);
    cmd(`DMCD_OP_FULL_SCREEN, 4'h0);
    cmd(`DMCD_OP_FULL_SCREEN, 4'h0);
    ahb(1'h0, `DMCD_ADDR_LAST_OP, 32'h0, r);
    chk(r, 32'h13);
  endtask

  task automatic t_invert;
    cmd(`DMCD_OP_INVERT_OFF, 4'h0);
    cmd(`DMCD_OP_INVERT_ON, 4'h4);
    cmd(`DMCD_OP_WINDOW_ON, 4'h5);
    cmd(`DMCD_OP_INVERT_OFF, 4'h1);
    cmd(`DMCD_OP_FULL_SCREEN, 4'h0);
  endtask

  // Data cycles and disabled decoding must not change any flag
  task automatic t_refuse;
    logic [31:0] r;
    host_u.send(1'h1, `DMCD_OP_WINDOW_ON);
    chk_state(4'h0);
    ahb(1'h1, `DMCD_ADDR_CONTROL, 32'h0, r);
    cmd(`DMCD_OP_INVERT_ON, 4'h0);
    ahb(1'h1, `DMCD_ADDR_CONTROL, 32'h1, r);
    cmd(`DMCD_OP_INVERT_ON, 4'h4);
  endtask

  // Area, software reset, then a hardware reset in mid-run
  task automatic t_resets;
    cmd(`DMCD_OP_WINDOW_AREA, 4'hc);
    cmd(`DMCD_OP_WINDOW_ON, 4'hd);
    cmd(`DMCD_OP_SW_RESET, 4'h8);
    cmd(`DMCD_OP_INVERT_ON, 4'hc);
    cmd(`DMCD_OP_WINDOW_ON, 4'hd);
    @(posedge sys_clk_in);
    reset_n_in <= 1'h0;
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'h1;
    chk_state(4'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    n_mismatch = 0;
    tests_run  = 0;
    reset_n_in = 1'h0;
    hsel       = 1'h0;
    hwrite     = 1'h0;
    htrans     = 2'h0;
    haddr      = 32'h0;
    hwdata     = 32'h0;
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'h1;
    t_reset();
    t_window();
    t_invert();
    t_refuse();
    t_resets();
    close_out();
  end
endmodule
